// file: common/mrt_cfg.svh
// constants of the measurement recording trigger
`ifndef MRT_CFG_SVH
`define MRT_CFG_SVH
`define MRT_ALLOC_MIN 17'h00001
`define MRT_ALLOC_MAX 17'h186A0
`define MRT_ALLOC_RST 17'h003E8
`define MRT_IVL_MAX 17'h186A0
`define MRT_IVL_RST 17'h00064
`define MRT_THR_MAX 32'sh001E8480
`define MRT_THR_RST 32'sh00000000
`define MRT_OFS_MAX 17'h0C350
`define MRT_OFS_RST 17'sh00000
`define MRT_CHAN_RST 2'h0
`define MRT_FIFO_DEPTH 16
`define MRT_DATA_W 32
`endif

// file: common/mrt_pkg.sv
// types of the measurement recording trigger
package mrt_pkg;
  typedef enum logic [2:0] {
    MRT_START_IMMEDIATE,
    MRT_START_ERR_OFF,
    MRT_START_ERR_ON,
    MRT_START_UPPER,
    MRT_START_LOWER,
    MRT_START_BOTH
  } mrt_start_t;
  typedef enum logic [1:0] {
    MRT_CHAN_A,
    MRT_CHAN_B,
    MRT_CHAN_C,
    MRT_CHAN_D
  } mrt_chan_t;
endpackage

// file: common/mrt_stream_if.sv
// valid/ready word stream between recorder modules
`timescale 1ns/1ps
`default_nettype none
interface mrt_stream_if;
  logic valid;
  logic ready;
  logic [31:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// file: src/mrt_fifo.sv
// synchronous fifo with registered read data
`timescale 1ns/1ps
`default_nettype none
module mrt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic flush,
  mrt_stream_if.snk in_s,
  mrt_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [WIDTH-1:0] out_data;
  logic out_valid;
  wire push = in_s.valid && in_s.ready;
  wire pop_mem = (count != '0) && (!out_valid || out_s.ready);
  assign in_s.ready = (count != DEPTH[AW:0]) && !flush;
  assign out_s.valid = out_valid;
  assign out_s.data = out_data;
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
    if (pop_mem) begin
      out_data <= mem[rd_ptr];
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop_mem ? rd_ptr + 1'b1 : rd_ptr;
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};
      if (pop_mem) begin
        out_valid <= 1'b1;
      end else if (out_s.ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule // mrt_fifo
`default_nettype wire

// file: src/mrt_recorder.sv
// measurement recording trigger and store control
`timescale 1ns/1ps
`default_nettype none
`include "mrt_cfg.svh"
// Notes on behaviour
// R1: a start request opens a fresh record and begins accepting entries.
// R2: a stop request ends accepting entries and closes and keeps the record.
// R3: allocation sets the entry count, limited to 1..100000, default 1000.
// R4: reaching the allocation closes and keeps the record without a stop.
// R5: interval 1 stores every sample, interval n stores every nth sample.
// R6: interval accepts 0..100000 and defaults to 100.
// R7: single value recording forces the interval to 1.
// R8: immediate start stores from the start with no event wait.
// R9: error off starts when measuring is possible, error on when it is not.
// R10: upper, lower and both thresholds start on exceed, fall below, either.
// R11: threshold spans plus or minus 2000.000 mm in um, default 0.
// R12: the start condition looks at one channel A to D, default A.
// R13: output format selects decimal point or comma and comma or semicolon.
// R14: a positive offset delays storing, a negative one keeps prior samples.
// R15: conditions and interval act once per sample; later triggers ignored.
module mrt_recorder
  import mrt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cfg_reset,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic [16:0] alloc_cfg,
  input wire logic [16:0] interval_cfg,
  input wire logic single_value_sel,
  input wire logic [2:0] start_cond_cfg,
  input wire logic [31:0] threshold_cfg,
  input wire logic [1:0] trig_chan_cfg,
  input wire logic [16:0] start_ofs_cfg,
  input wire logic dec_comma_cfg,
  input wire logic col_semicolon_cfg,
  input wire logic cfg_load,
  input wire logic sample_valid,
  input wire logic [31:0] sample_a,
  input wire logic [31:0] sample_b,
  input wire logic [31:0] sample_c,
  input wire logic [31:0] sample_d,
  input wire logic [3:0] meas_ok,
  output logic rec_open,
  output logic rec_storing,
  output logic rec_closed,
  output logic rec_full,
  output logic [16:0] entry_count,
  output logic [16:0] interval_eff,
  output logic [16:0] alloc_eff,
  output logic dec_comma,
  output logic col_semicolon,
  output logic entry_valid,
  input wire logic entry_ready,
  output logic [31:0] entry_data
);
  typedef enum logic [1:0] {MRT_IDLE, MRT_ARMED, MRT_DELAY, MRT_STORE} mrt_st_t;
  mrt_st_t state;
  mrt_st_t next_state;
  logic [16:0] alloc_reg;
  logic [16:0] interval_reg;
  logic signed [31:0] thr_reg;
  logic [2:0] cond_reg;
  logic [1:0] chan_reg;
  logic signed [16:0] ofs_reg;
  logic [16:0] ivl_cnt;
  logic [16:0] delay_cnt;
  logic [16:0] pre_cnt;
  logic [16:0] pre_drop;
  logic prev_ok;
  logic prev_above;
  logic prev_below;
  logic prev_known;
  mrt_stream_if fin();
  mrt_stream_if fout();

  // clamp a 17-bit setting into its legal range
  function automatic logic [16:0] clamp17(input logic [16:0] v,
                                          input logic [16:0] lo,
                                          input logic [16:0] hi);
    clamp17 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  wire [16:0] next_alloc = clamp17(alloc_cfg, `MRT_ALLOC_MIN,
                                   `MRT_ALLOC_MAX); // R3
  wire [16:0] next_ivl = clamp17(interval_cfg, 17'h00000,
                                 `MRT_IVL_MAX); // R6
  wire signed [31:0] thr_in = threshold_cfg;
  wire signed [31:0] next_thr = (thr_in > `MRT_THR_MAX) ? `MRT_THR_MAX :
    ((thr_in < -`MRT_THR_MAX) ? -`MRT_THR_MAX : thr_in); // R11
  wire signed [16:0] ofs_in = start_ofs_cfg;
  wire signed [16:0] ofs_max = `MRT_OFS_MAX;
  wire signed [16:0] next_ofs = (ofs_in > ofs_max) ? ofs_max :
    ((ofs_in < -ofs_max) ? -ofs_max : ofs_in); // R14
  wire [2:0] next_cond = (start_cond_cfg > 3'(MRT_START_BOTH)) ?
    3'(MRT_START_IMMEDIATE) : start_cond_cfg;

  // channel selection for trigger evaluation
  wire signed [31:0] trig_val = (chan_reg == 2'(MRT_CHAN_A)) ? sample_a :
    (chan_reg == 2'(MRT_CHAN_B)) ? sample_b :
    (chan_reg == 2'(MRT_CHAN_C)) ? sample_c : sample_d; // R12
  wire trig_ok = meas_ok[chan_reg]; // R12
  wire is_above = trig_val > thr_reg;
  wire is_below = trig_val < thr_reg;

  // threshold edges need a prior sample so a level already true does not fire; error starts also fire on the first sample
  wire ev_err_off = trig_ok && (!prev_known || !prev_ok); // R9
  wire ev_err_on = !trig_ok && (!prev_known || prev_ok); // R9
  wire ev_upper = is_above && prev_known && !prev_above; // R10
  wire ev_lower = is_below && prev_known && !prev_below; // R10
  wire trig_hit = (cond_reg == 3'(MRT_START_IMMEDIATE)) ? 1'b1 : // R8
    (cond_reg == 3'(MRT_START_ERR_OFF)) ? ev_err_off :
    (cond_reg == 3'(MRT_START_ERR_ON)) ? ev_err_on :
    (cond_reg == 3'(MRT_START_UPPER)) ? ev_upper :
    (cond_reg == 3'(MRT_START_LOWER)) ? ev_lower :
    (ev_upper || ev_lower); // R10

  wire stop_now = stop_req && rec_open; // R2
  wire full_now = (entry_count >= alloc_reg) && rec_open; // R4
  wire closing = stop_now || full_now;
  wire ivl_hit = (interval_reg <= 17'h00001) ||
    (ivl_cnt + 17'h00001 >= interval_reg); // R5
  wire pos_ofs = !ofs_reg[16] && (ofs_reg != 17'sh00000);
  wire [16:0] neg_mag = 17'(-ofs_reg);

  // while armed with a negative offset, pre-trigger samples are buffered;
  // the fifo depth bounds how many prior samples can really be kept
  wire pre_take = (state == MRT_ARMED) && ofs_reg[16] && sample_valid;
  wire store_take = (state == MRT_STORE) && sample_valid && ivl_hit &&
    !closing; // R5 R15
  assign fin.valid = (pre_take || store_take) && fin.ready;
  assign fin.data = trig_val;
  wire accepted = fin.valid && (state == MRT_STORE);
  // oldest pre samples beyond the offset are discarded from the fifo head
  wire drop_pre = (pre_drop != 17'h00000) && fout.valid;
  assign fout.ready = drop_pre || entry_ready;
  assign entry_valid = fout.valid && !drop_pre;
  assign entry_data = fout.data;

  always_comb begin
    next_state = state;
    case (state)
      MRT_IDLE: begin
        if (start_req) begin
          next_state = MRT_ARMED; // R1
        end
      end
      MRT_ARMED: begin
        if (stop_req) begin
          next_state = MRT_IDLE; // R2
        end else if (sample_valid && trig_hit) begin
          next_state = pos_ofs ? MRT_DELAY : MRT_STORE; // R14
        end
      end
      MRT_DELAY: begin
        if (stop_req) begin
          next_state = MRT_IDLE;
        end else if (sample_valid && delay_cnt + 17'h00001 >= 17'(ofs_reg)) begin
          next_state = MRT_STORE; // R14
        end
      end
      MRT_STORE: begin
        if (closing) begin
          next_state = MRT_IDLE; // R2 R4
        end
      end
      default: next_state = MRT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alloc_reg <= `MRT_ALLOC_RST;
      interval_reg <= `MRT_IVL_RST;
      thr_reg <= `MRT_THR_RST;
      cond_reg <= 3'(MRT_START_IMMEDIATE);
      chan_reg <= `MRT_CHAN_RST;
      ofs_reg <= `MRT_OFS_RST;
      dec_comma <= 1'b0;
      col_semicolon <= 1'b0;
    end else if (cfg_reset) begin
      alloc_reg <= `MRT_ALLOC_RST; // R3
      interval_reg <= `MRT_IVL_RST; // R6
      thr_reg <= `MRT_THR_RST; // R11
      cond_reg <= 3'(MRT_START_IMMEDIATE); // R8
      chan_reg <= `MRT_CHAN_RST; // R12
      ofs_reg <= `MRT_OFS_RST; // R14
      dec_comma <= 1'b0;
      col_semicolon <= 1'b0;
    end else begin
      if (cfg_load && !rec_open) begin
        alloc_reg <= next_alloc;
        interval_reg <= next_ivl;
        thr_reg <= next_thr;
        cond_reg <= next_cond;
        chan_reg <= trig_chan_cfg;
        ofs_reg <= next_ofs;
        dec_comma <= dec_comma_cfg; // R13
        col_semicolon <= col_semicolon_cfg; // R13
      end
      if (single_value_sel) begin
        interval_reg <= 17'h00001; // R7
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= MRT_IDLE;
      rec_closed <= 1'b0;
      rec_full <= 1'b0;
      entry_count <= '0;
      ivl_cnt <= '0;
      delay_cnt <= '0;
      pre_cnt <= '0;
      pre_drop <= '0;
      prev_ok <= 1'b0;
      prev_above <= 1'b0;
      prev_below <= 1'b0;
      prev_known <= 1'b0;
    end else begin
      state <= next_state;
      if (state == MRT_IDLE && start_req) begin
        rec_closed <= 1'b0; // R1
        rec_full <= 1'b0;
        entry_count <= '0;
        ivl_cnt <= '0;
        delay_cnt <= '0;
        pre_cnt <= '0;
        pre_drop <= '0;
        prev_known <= 1'b0;
      end else begin
        if (rec_open && (closing || (state != MRT_STORE && stop_req))) begin
          rec_closed <= 1'b1; // R2 R4
        end
        if (full_now && !stop_now) begin
          rec_full <= 1'b1; // R4
        end
        if (accepted) begin
          entry_count <= entry_count + 17'h00001;
        end
        if (state == MRT_STORE && sample_valid) begin
          ivl_cnt <= ivl_hit ? 17'h00000 : ivl_cnt + 17'h00001; // R5 R15
        end
        if (state == MRT_DELAY && sample_valid) begin
          delay_cnt <= delay_cnt + 17'h00001; // R14
        end
        if (pre_take && fin.valid) begin
          pre_cnt <= pre_cnt + 17'h00001; // R14
        end
        if (state == MRT_ARMED && next_state == MRT_STORE && ofs_reg[16]) begin
          // trigger sample itself is stored after the kept prior ones
          pre_drop <= (pre_cnt > neg_mag) ? 17'(pre_cnt - neg_mag) : '0;
          entry_count <= (pre_cnt > neg_mag) ? neg_mag : pre_cnt;
        end else if (drop_pre) begin
          pre_drop <= pre_drop - 17'h00001;
        end
      end
      // trigger history is sampled only on new samples while armed
      if (state == MRT_ARMED && sample_valid) begin
        prev_ok <= trig_ok; // R15
        prev_above <= is_above;
        prev_below <= is_below;
        prev_known <= 1'b1;
      end
    end
  end

  assign rec_open = (state != MRT_IDLE); // R1
  assign rec_storing = (state == MRT_STORE); // R15
  assign interval_eff = interval_reg;
  assign alloc_eff = alloc_reg;

  mrt_fifo #(
    .WIDTH(`MRT_DATA_W),
    .DEPTH(`MRT_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .flush(state == MRT_IDLE && start_req),
    .in_s(fin),
    .out_s(fout)
  );
endmodule // mrt_recorder
`default_nettype wire

// file: test/mrt_recorder_asserts.sv
// port assertions for the recorder
`timescale 1ns/1ps
`default_nettype none
`include "mrt_cfg.svh"
module mrt_recorder_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cfg_reset,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic single_value_sel,
  input wire logic rec_open,
  input wire logic rec_storing,
  input wire logic rec_closed,
  input wire logic rec_full,
  input wire logic [16:0] entry_count,
  input wire logic [16:0] interval_eff,
  input wire logic [16:0] alloc_eff,
  input wire logic dec_comma,
  input wire logic col_semicolon,
  input wire logic entry_valid,
  input wire logic entry_ready,
  input wire logic [31:0] entry_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  start_opens_a: assert property (start_req && !rec_open |=>
    rec_open && !rec_closed) else $error("start did not open a record");
  stop_closes_a: assert property (stop_req && rec_open |=>
    !rec_open && rec_closed) else $error("stop did not close the record");
  stop_not_full_a: assert property (stop_req && rec_open &&
    entry_count < alloc_eff |=> !rec_full) else $error("stop marked full");
  full_closes_a: assert property (rec_storing && !stop_req &&
    entry_count >= alloc_eff |=> rec_full && rec_closed && !rec_open)
    else $error("allocation reached but record open");
  idle_hold_a: assert property (!rec_open && !start_req |=>
    $stable(entry_count) && !rec_storing) else $error("idle count moved");
  eff_range_a: assert property (alloc_eff >= `MRT_ALLOC_MIN &&
    alloc_eff <= `MRT_ALLOC_MAX && interval_eff <= `MRT_IVL_MAX)
    else $error("effective setting out of range");
  single_value_a: assert property (single_value_sel && !cfg_reset |=>
    interval_eff == 17'h00001) else $error("interval not forced to one");
  cfg_defaults_a: assert property (cfg_reset && !single_value_sel &&
    !rec_open |=> alloc_eff == `MRT_ALLOC_RST &&
    interval_eff == `MRT_IVL_RST && !dec_comma && !col_semicolon)
    else $error("settings not back at defaults");
  entry_hold_a: assert property (entry_valid && !entry_ready |=>
    entry_valid && $stable(entry_data)) else $error("entry dropped");
endmodule // mrt_recorder_asserts
bind mrt_recorder mrt_recorder_asserts chk (.ref_clk, .resetn, .cfg_reset,
  .start_req, .stop_req, .single_value_sel, .rec_open, .rec_storing,
  .rec_closed, .rec_full, .entry_count, .interval_eff, .alloc_eff,
  .dec_comma, .col_semicolon, .entry_valid, .entry_ready, .entry_data);
`default_nettype wire

// file: test/test_mrt_recorder.sv
// self-checking bench for the recorder
`timescale 1ns/1ps
`default_nettype none
`include "mrt_cfg.svh"
module test_mrt_recorder;
  logic ref_clk, resetn, cfg_reset, start_req, stop_req, single_value_sel;
  logic [16:0] alloc_cfg, interval_cfg, start_ofs_cfg;
  logic [2:0] start_cond_cfg;
  logic [31:0] threshold_cfg, entry_data, th, vi, vf;
  logic [1:0] trig_chan_cfg, ch;
  logic dec_comma_cfg, col_semicolon_cfg, cfg_load, sample_valid;
  logic [31:0] sv [4];
  logic [3:0] meas_ok, mask, mi, mf;
  logic rec_open, rec_storing, rec_closed, rec_full, dec_comma;
  logic col_semicolon, entry_valid, entry_ready;
  logic [16:0] entry_count, interval_eff, alloc_eff, exp_al, exp_iv, cnt;
  logic [1:0] exp_f;
  logic [31:0] q[$], got[$];
  int mismatches, compares;
  mrt_recorder dut (.ref_clk, .resetn, .cfg_reset, .start_req, .stop_req,
    .alloc_cfg, .interval_cfg, .single_value_sel, .start_cond_cfg,
    .threshold_cfg, .trig_chan_cfg, .start_ofs_cfg, .dec_comma_cfg,
    .col_semicolon_cfg, .cfg_load, .sample_valid, .sample_a(sv[0]),
    .sample_b(sv[1]), .sample_c(sv[2]), .sample_d(sv[3]), .meas_ok,
    .rec_open, .rec_storing, .rec_closed, .rec_full, .entry_count,
    .interval_eff, .alloc_eff, .dec_comma, .col_semicolon, .entry_valid,
    .entry_ready, .entry_data);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (entry_valid === 1'b1 && entry_ready === 1'b1) got.push_back(entry_data);
    entry_ready <= 1'($urandom);
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic test_done;
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic load(input logic [16:0] al, iv, input logic [2:0] cd,
      input logic [31:0] t);
    logic [1:0] f;
    f = 2'($urandom);
    @(posedge ref_clk);
    // expectations read the switch only after its own update has landed
    if (rec_open !== 1'b1) begin
      exp_al = al == 17'h0 ? 17'h1 : al > `MRT_ALLOC_MAX ? `MRT_ALLOC_MAX : al;
      exp_iv = single_value_sel ? 17'h1 : iv > `MRT_IVL_MAX ? `MRT_IVL_MAX : iv;
      exp_f = f;
    end
    {alloc_cfg, interval_cfg, start_cond_cfg} <= {al, iv, cd};
    {threshold_cfg, trig_chan_cfg} <= {t, ch};
    {dec_comma_cfg, col_semicolon_cfg} <= f;
    cfg_load <= 1'b1;
    @(posedge ref_clk);
    cfg_load <= 1'b0;
    @(negedge ref_clk);
    chk("alloc_eff", 32'(exp_al), 32'(alloc_eff));
    chk("interval_eff", 32'(exp_iv), 32'(interval_eff));
    chk("format", 32'(exp_f), 32'({dec_comma, col_semicolon}));
  endtask
  task automatic pulse_start;
    q.delete();
    got.delete();
    @(posedge ref_clk);
    start_req <= 1'b1;
    @(posedge ref_clk);
    start_req <= 1'b0;
    @(negedge ref_clk);
    chk("rec_open", 32'h1, 32'(rec_open));
    chk("rec_closed", 32'h0, 32'(rec_closed));
  endtask
  task automatic put(input logic [31:0] v, o, input logic [3:0] mk);
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) sv[i] <= (i == ch) ? v : o;
    meas_ok <= mk;
    sample_valid <= 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic halt;
    if (rec_open === 1'b1) begin
      @(posedge ref_clk);
      stop_req <= 1'b1;
      @(posedge ref_clk);
      stop_req <= 1'b0;
    end
    @(negedge ref_clk);
    chk("rec_closed", 32'h1, 32'(rec_closed));
    for (int t = 0; t < 300 && entry_valid !== 1'b0; t++) @(negedge ref_clk);
    chk("entry_valid", 32'h0, 32'(entry_valid));
  endtask
  initial begin
    {resetn, cfg_reset, start_req, stop_req, single_value_sel} = 5'h0;
    {alloc_cfg, interval_cfg, start_ofs_cfg, start_cond_cfg} = 54'h0;
    {threshold_cfg, trig_chan_cfg, dec_comma_cfg, col_semicolon_cfg} = 36'h0;
    {cfg_load, sample_valid, meas_ok, ch} = 8'h0;
    for (int i = 0; i < 4; i++) sv[i] = 32'h0;
    void'($urandom(39429));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk("alloc_eff", `MRT_ALLOC_RST, 32'(alloc_eff));
    chk("interval_eff", `MRT_IVL_RST, 32'(interval_eff));
    for (int i = 0; i < 6; i++) load(i == 0 ? 17'h0 : i == 1 ? 17'h1FFFF :
      17'($urandom), i == 0 ? 17'h1FFFF : 17'($urandom), 3'h0, 32'h0);
    for (int i = 0; i < 5; i++) begin
      ch = 2'($urandom);
      single_value_sel <= (i == 0);
      load(i == 4 ? 17'h3 : 17'h32, i == 0 ? 17'h64 : 17'(i - 1), 3'h0, 32'h0);
      pulse_start;
      put($urandom, $urandom, 4'hF);
      chk("rec_storing", 32'h1, 32'(rec_storing));
      for (int j = 0; j < 12; j++) begin
        q.push_back($urandom);
        put(q[j], ~q[j], 4'hF);
      end
      cnt = 17'h0C / (exp_iv == 17'h0 ? 17'h1 : exp_iv);
      if (cnt > exp_al) cnt = exp_al;
      chk("rec_full", 32'(cnt == exp_al), 32'(rec_full));
      halt;
      chk("entry_count", 32'(cnt), 32'(entry_count));
      chk("entries", 32'(cnt), got.size());
      if (exp_iv < 17'h2) for (int j = 0; j < cnt; j++) chk("entry", q[j], got[j]);
    end
    single_value_sel <= 1'b0;
    for (int c = 1; c < 6; c++) begin
      ch = 2'($urandom);
      // keep both test values around the threshold inside the clamp range
      th = 32'($urandom_range(32'h003D08D8)) - 32'h001E8476;
      mask = 4'h1 << ch;
      vi = $urandom;
      vf = vi;
      {mi, mf} = 8'hFF;
      case (c)
        1: mi = ~mask;
        2: {mi, mf} = {mask, 4'h0};
        3: {vi, vf} = {th - 32'h5, th + 32'h5};
        default: {vi, vf} = {th + 32'h5, th - 32'h5};
      endcase
      load(17'h32, 17'h1, 3'(c), th);
      pulse_start;
      load(17'h7, 17'h1, 3'h0, th);
      repeat (3) put(vi, vf, mi);
      chk("rec_storing", 32'h0, 32'(rec_storing));
      put(vf, vf, mf);
      chk("rec_storing", 32'h1, 32'(rec_storing));
      put(vi, vf, mi);
      chk("rec_storing", 32'h1, 32'(rec_storing));
      halt;
    end
    @(posedge ref_clk);
    start_ofs_cfg <= 17'h00003;
    load(17'h32, 17'h1, 3'h0, 32'h0);
    pulse_start;
    put($urandom, $urandom, 4'hF);
    chk("rec_open", 32'h1, 32'(rec_open));
    repeat (2) put($urandom, $urandom, 4'hF);
    chk("rec_storing", 32'h0, 32'(rec_storing));
    put($urandom, $urandom, 4'hF);
    chk("rec_storing", 32'h1, 32'(rec_storing));
    halt;
    @(posedge ref_clk);
    cfg_reset <= 1'b1;
    @(posedge ref_clk);
    cfg_reset <= 1'b0;
    @(negedge ref_clk);
    chk("alloc_eff", `MRT_ALLOC_RST, 32'(alloc_eff));
    chk("interval_eff", `MRT_IVL_RST, 32'(interval_eff));
    test_done;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done;
  end
endmodule // test_mrt_recorder
`default_nettype wire
